// File: testbench/hbp_dev_model.sv
// Behavioural model of the switch's host bus pins: a word store and two data FIFOs.
`timescale 1ns/1ns
module hbp_dev_model
  import hbp_pkg::*;
#(
  parameter logic [DATA_W-1:0] RX_A = 16'hbeef,
  parameter logic [DATA_W-1:0] RX_B = 16'h0f0f
) (
  input  wire logic              cs_n_i,
  input  wire logic              rd_n_i,
  input  wire logic              wr_n_i,
  input  wire logic              fifo_sel_i,
  input  wire logic              end_sel_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic                   drive_o
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] tx_q [$];
  logic [DATA_W-1:0] rx_q [$] = '{RX_A, RX_B};
  logic [DATA_W-1:0] rval = 16'h0000;
  function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] v, input logic be);
    return be ? {v[7:0], v[15:8]} : v;
  endfunction
  // Write data is taken as the strobe rises, so a FIFO word is pushed once however long it is low.
  always @(posedge wr_n_i) begin
    if (!cs_n_i) begin
      if (fifo_sel_i)
        tx_q.push_back(order(data_i, end_sel_i));
      else
        mem[addr_i] = order(data_i, end_sel_i);
    end
  end
  always @(negedge rd_n_i) begin
    if (!cs_n_i) begin
      if (fifo_sel_i)
        rval = order(rx_q.pop_front(), end_sel_i);
      else
        rval = order(mem[addr_i], end_sel_i);
    end
  end
  // Released lines show the inverse of the last word, so a late sample is caught.
  assign drive_o = !cs_n_i && !rd_n_i;
  assign data_o  = drive_o ? rval : ~rval;
endmodule

// File: testbench/tb.sv
// Self-checking bench for the host bus pin controller against the switch model.
`timescale 1ns/1ns
module tb;
  import hbp_pkg::*;
  localparam logic [DATA_W-1:0] RX_A = 16'hbeef;
  localparam logic [DATA_W-1:0] RX_B = 16'h0f0f;
  logic              core_clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  hbp_req_t          req = '0;
  hbp_rsp_t          rsp;
  logic              req_ready, data_oe_n, cs_n, rd_n, wr_n, fifo_sel, end_sel, dev_drv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] h_data, dev_data, bus, rd_val;
  int                bad_count = 0;
  int                samples_checked = 0;
  assign bus = !data_oe_n ? h_data : dev_data;
  hbp_host u_dut (
    .core_clk_i         (core_clk_i),
    .rst_n_i            (rst_n_i),
    .req_i              (req),
    .req_ready_o        (req_ready),
    .rsp_o              (rsp),
    .addr_o             (addr),
    .data_o             (h_data),
    .data_oe_n_o        (data_oe_n),
    .data_i             (bus),
    .chip_select_low_o  (cs_n),
    .read_strobe_low_o  (rd_n),
    .write_strobe_low_o (wr_n),
    .fifo_sel_o         (fifo_sel),
    .end_sel_o          (end_sel)
  );
  hbp_dev_model #(.RX_A(RX_A), .RX_B(RX_B)) u_dev (
    .cs_n_i     (cs_n),
    .rd_n_i     (rd_n),
    .wr_n_i     (wr_n),
    .fifo_sel_i (fifo_sel),
    .end_sel_i  (end_sel),
    .addr_i     (addr),
    .data_i     (bus),
    .data_o     (dev_data),
    .drive_o    (dev_drv)
  );
  task automatic test_done();
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One word access; a stalled handshake ends the run rather than hanging it.
  task automatic access(input logic wr, input logic fifo, input logic be, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] wd);
    int   n;
    int   m;
    logic oe_seen;
    req <= '{valid: 1'b1, write: wr, fifo: fifo, big_endian: be, addr: a, wdata: wd};
    n = 0;
    m = 0;
    oe_seen = 1'b0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    req <= '0;
    do begin
      @(posedge core_clk_i);
      m++;
      if (data_oe_n === 1'b0)
        oe_seen = 1'b1;
    end while (rsp.valid !== 1'b1 && m < 20);
    if (n >= 20 || m >= 20) begin
      bad_count++;
      test_done();
    end else begin
      chk("latency", 16'(m), 16'(SETUP_CYC + STROBE_CYC + HOLD_CYC + 1));
      chk("host drives data", 16'(oe_seen), 16'(wr));
      rd_val = rsp.rdata;
    end
  endtask
  task automatic sc_regs();
    access(1'b1, 1'b0, 1'b0, 9'h1ff, 16'h1234);
    access(1'b0, 1'b0, 1'b0, 9'h1ff, 16'h0000);
    chk("read le", rd_val, 16'h1234);
    access(1'b0, 1'b0, 1'b1, 9'h1ff, 16'h0000);
    chk("read be", rd_val, 16'h3412);
    access(1'b1, 1'b0, 1'b1, 9'h001, 16'habcd);
    access(1'b0, 1'b0, 1'b0, 9'h001, 16'h0000);
    chk("write be", rd_val, 16'hcdab);
  endtask
  task automatic sc_fifo();
    access(1'b1, 1'b1, 1'b0, 9'h1ff, 16'h5a5a);
    chk("tx fifo", u_dev.tx_q[0], 16'h5a5a);
    access(1'b0, 1'b1, 1'b0, 9'h1ff, 16'h0000);
    chk("rx fifo a", rd_val, RX_A);
    access(1'b0, 1'b1, 1'b1, 9'h001, 16'h0000);
    chk("rx fifo b", rd_val, {RX_B[7:0], RX_B[15:8]});
    access(1'b0, 1'b0, 1'b0, 9'h1ff, 16'h0000);
    chk("store kept", rd_val, 16'h1234);
  endtask
  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sc_regs();
    sc_fifo();
    test_done();
  end
endmodule

// File: verilog/hbp_host.sv
// Host controller that runs word accesses on the switch's SRAM-like host bus pins.
`timescale 1ns/1ns
module hbp_host
  import hbp_pkg::*;
#(
  parameter int SETUP_CYCLES  = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int HOLD_CYCLES   = HOLD_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire hbp_req_t          req_i,
  output logic                   req_ready_o,
  output hbp_rsp_t               rsp_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_n_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic                   chip_select_low_o,
  output logic                   read_strobe_low_o,
  output logic                   write_strobe_low_o,
  output logic                   fifo_sel_o,
  output logic                   end_sel_o
);

  if (SETUP_CYCLES < 1 || SETUP_CYCLES > 15 || STROBE_CYCLES < 1 || STROBE_CYCLES > 15 ||
      HOLD_CYCLES < 1 || HOLD_CYCLES > 15) begin : g_bad_timing
    $error("hbp_host: each phase must last 1 to 15 cycles.");
  end

  localparam logic [CNT_W-1:0] SETUP_LAST  = CNT_W'(SETUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST   = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;

  logic      rst_meta_r;
  logic      rst_sync_r;
  hbp_regs_t st_r;
  hbp_regs_t st_nxt;

  // The release is synchronised so that no phase starts on a partial edge.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_comb begin
    st_nxt           = st_r;
    st_nxt.rsp_valid = 1'b0;
    case (st_r.state)
      HBP_IDLE: begin
        if (req_i.valid) begin
          st_nxt.ready      = 1'b0;
          st_nxt.write      = req_i.write;
          st_nxt.rsp_write  = req_i.write;
          st_nxt.fifo_sel   = req_i.fifo;
          // Address is parked at zero in FIFO mode since the device ignores it.
          st_nxt.addr       = req_i.fifo ? ADDR_RST : req_i.addr;
          st_nxt.end_sel    = req_i.big_endian;
          st_nxt.wdata      = req_i.wdata;
          st_nxt.data_oe_n  = ~req_i.write;
          st_nxt.cs_n       = 1'b0;
          st_nxt.cnt        = SETUP_LAST;
          st_nxt.state      = HBP_SETUP;
        end
      end
      HBP_SETUP: begin
        if (st_r.cnt == '0) begin
          // Strobes only fall after chip select has settled for a full setup phase.
          st_nxt.rd_n  = st_r.write;
          st_nxt.wr_n  = ~st_r.write;
          st_nxt.cnt   = STROBE_LAST;
          st_nxt.state = HBP_STROBE;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      HBP_STROBE: begin
        if (st_r.cnt == '0) begin
          if (!st_r.write) begin
            st_nxt.rdata = data_i;
          end
          st_nxt.rd_n  = 1'b1;
          st_nxt.wr_n  = 1'b1;
          st_nxt.cnt   = HOLD_LAST;
          st_nxt.state = HBP_HOLD;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      HBP_HOLD: begin
        if (st_r.cnt == '0) begin
          st_nxt.cs_n      = 1'b1;
          st_nxt.data_oe_n = 1'b1;
          st_nxt.ready     = 1'b1;
          st_nxt.rsp_valid = 1'b1;
          st_nxt.state     = HBP_IDLE;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      default: begin
        st_nxt = REGS_RST;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= REGS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req_ready_o        = st_r.ready;
  assign rsp_o              = '{
    valid: st_r.rsp_valid,
    write: st_r.rsp_write,
    rdata: st_r.rdata
  };
  assign addr_o             = st_r.addr;
  assign data_o             = st_r.wdata;
  assign data_oe_n_o        = st_r.data_oe_n;
  assign chip_select_low_o  = st_r.cs_n;
  assign read_strobe_low_o  = st_r.rd_n;
  assign write_strobe_low_o = st_r.wr_n;
  assign fifo_sel_o         = st_r.fifo_sel;
  assign end_sel_o          = st_r.end_sel;

  // Helper counter of how long the current strobe has been low.
  logic [CNT_W-1:0] low_cnt_r;
  always_ff @(posedge core_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      low_cnt_r <= '0;
    end else if (!st_r.rd_n || !st_r.wr_n) begin
      low_cnt_r <= low_cnt_r + CNT_ONE;
    end else begin
      low_cnt_r <= '0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_sync_r);

  sequence seq_access_open;
    $fell(st_r.cs_n);
  endsequence

  sequence seq_strobe_end;
    $rose(st_r.rd_n) || $rose(st_r.wr_n);
  endsequence

  sequence seq_strobe_start;
    $fell(st_r.rd_n) || $fell(st_r.wr_n);
  endsequence

  a_read_qualified: assert property (!st_r.rd_n |-> !st_r.cs_n)
    else $error("Read strobe low without chip select.");
  a_write_qualified: assert property (!st_r.wr_n |-> !st_r.cs_n)
    else $error("Write strobe low without chip select.");
  a_single_strobe: assert property (!(!st_r.rd_n && !st_r.wr_n))
    else $error("Both strobes low together.");
  a_read_released: assert property (!st_r.rd_n |-> st_r.data_oe_n)
    else $error("Host drives data during a read.");
  a_write_drives: assert property (!st_r.wr_n |-> !st_r.data_oe_n)
    else $error("Host leaves data undriven during a write.");
  a_access_stable: assert property (!st_r.cs_n && $past(!st_r.cs_n) |->
      $stable(st_r.addr) && $stable(st_r.fifo_sel) && $stable(st_r.end_sel))
    else $error("Address or select pins moved inside an access.");
  a_fifo_addr_zero: assert property (!st_r.cs_n && st_r.fifo_sel |-> st_r.addr == ADDR_RST)
    else $error("Address not parked during a direct FIFO access.");
  a_strobe_width: assert property (seq_strobe_end |-> low_cnt_r == CNT_W'(STROBE_CYCLES))
    else $error("Strobe low time differs from the set width.");
  a_setup_before: assert property (seq_access_open |-> st_r.rd_n && st_r.wr_n)
    else $error("Strobe fell together with chip select.");
  a_answer_time: assert property (seq_strobe_end |-> ##[1:16] st_r.rsp_valid)
    else $error("No response after the strobe ended.");
  a_endsel_follow: assert property (seq_access_open |-> st_r.end_sel == $past(req_i.big_endian))
    else $error("Byte order pin does not match the request.");
  // The next two checks pin down the order of the phases, since the device latches on strobe edges.
  a_strobe_after_cs: assert property (seq_strobe_start |-> $past(!st_r.cs_n))
    else $error("Strobe fell without chip select low the cycle before.");
  a_hold_before_cs: assert property (seq_strobe_end |-> !st_r.cs_n)
    else $error("Chip select rose together with the strobe.");
  a_idle_released: assert property (st_r.cs_n |-> st_r.data_oe_n)
    else $error("Host drives data outside an access.");
  a_oe_by_kind: assert property (!st_r.cs_n |-> st_r.data_oe_n == !st_r.write)
    else $error("Data drive does not match the access kind.");
  a_data_held: assert property (!st_r.data_oe_n && $past(!st_r.data_oe_n) |-> $stable(st_r.wdata))
    else $error("Write data moved while driven.");
  a_busy_not_ready: assert property (!st_r.cs_n |-> !st_r.ready)
    else $error("Ready high while an access is open.");
  a_rsp_single: assert property (st_r.rsp_valid |=> !st_r.rsp_valid)
    else $error("Response valid stood longer than one cycle.");
  a_rsp_after_access: assert property (st_r.rsp_valid |-> $past(!st_r.cs_n))
    else $error("Response without a preceding access.");
  a_rsp_at_close: assert property ($rose(st_r.cs_n) |-> st_r.rsp_valid)
    else $error("Chip select rose without a response.");
  a_wdata_taken: assert property ($fell(st_r.cs_n) && !st_r.data_oe_n |-> st_r.wdata == $past(req_i.wdata))
    else $error("Write data does not match the request.");
  a_addr_taken: assert property ($fell(st_r.cs_n) && !st_r.fifo_sel |-> st_r.addr == $past(req_i.addr))
    else $error("Address does not match the request.");
  a_fifo_taken: assert property (seq_access_open |-> st_r.fifo_sel == $past(req_i.fifo))
    else $error("Direct FIFO select does not match the request.");
  a_read_sample: assert property ($rose(st_r.rd_n) |-> st_r.rdata == $past(data_i))
    else $error("Read data not taken at the last strobe cycle.");

endmodule

// File: verilog/hbp_pkg.sv
// Package with pin timing, state encoding and state record of the host bus pin controller.
package hbp_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W        = 9;
  localparam int DATA_W        = 16;
  localparam int CNT_W         = 4;

  // Least times; each rounds up to whole cycles and never below one.
  localparam int SETUP_NS  = 50;
  localparam int STROBE_NS = 100;
  localparam int HOLD_NS   = 50;

  localparam int SETUP_CYC_RAW  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC_RAW = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC_RAW   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int SETUP_CYC  = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam int STROBE_CYC = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  localparam int HOLD_CYC   = (HOLD_CYC_RAW < 1) ? 1 : HOLD_CYC_RAW;

  typedef enum logic [1:0] {
    HBP_IDLE   = 2'h0,
    HBP_SETUP  = 2'h1,
    HBP_STROBE = 2'h2,
    HBP_HOLD   = 2'h3
  } hbp_state_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic              fifo;
    logic              big_endian;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbp_req_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [DATA_W-1:0] rdata;
  } hbp_rsp_t;

  typedef struct packed {
    hbp_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic              write;
    logic              ready;
    logic              rsp_valid;
    logic              rsp_write;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              data_oe_n;
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic              fifo_sel;
    logic              end_sel;
  } hbp_regs_t;

  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  localparam hbp_regs_t REGS_RST = '{
    state:     HBP_IDLE,
    cnt:       4'h0,
    write:     1'b0,
    ready:     1'b1,
    rsp_valid: 1'b0,
    rsp_write: 1'b0,
    rdata:     DATA_RST,
    addr:      ADDR_RST,
    wdata:     DATA_RST,
    data_oe_n: 1'b1,
    cs_n:      1'b1,
    rd_n:      1'b1,
    wr_n:      1'b1,
    fifo_sel:  1'b0,
    end_sel:   1'b0
  };

endpackage
